// file: design/agc_attack_regs.vh
// Purpose: offsets, reset values and widths for the attack-rate block
// Assumes: byte-wide register port, 8-bit address
// Notes:   definitions only
`ifndef AGC_ATTACK_REGS_VH
`define AGC_ATTACK_REGS_VH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SAT_ATTACK_LOW_ADDR   8'h1A
`define SAT_ATTACK_HIGH_ADDR  8'h1B
`define MONO_ATTACK_LOW_ADDR  8'h1F
`define MONO_ATTACK_HIGH_ADDR 8'h20
`define GAIN_STATUS_SEL_ADDR  8'hF0
`define GAIN_STATUS_LOW_ADDR  8'hF1
`define GAIN_STATUS_HIGH_ADDR 8'hF2

// ----------------------------------------------------------------------
// reset values and widths
// ----------------------------------------------------------------------
`define ATTACK_RESET          8'h00
`define GAIN_UNITY            16'hFFFF
`define GAIN_W                16
`define SAT_CHANNELS          2
`define UNMAPPED_READ         8'h00

`endif

// file: design/agc_gain_stage.v
// Purpose: one gain-control stage that cuts gain at the attack rate
// Assumes: averaged amplitude and thresholds come from the core
// Notes:   release and noise-gate handling live elsewhere
`timescale 1ns/1ns
`include "agc_attack_regs.vh"

module agc_gain_stage (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // control
  input  wire [15:0] attack_i,
  input  wire        step_i,
  input  wire [15:0] avg_amp_i,
  input  wire [15:0] thr_hi_i,
  // state
  output reg  [15:0] gain_o
);

  // ------------------------------------------------------------------
  // attack step
  // ------------------------------------------------------------------
  wire [31:0] prod;
  wire [15:0] cut;
  reg  [15:0] gain_nxt;

  // code/65536 times gain, upper half is the fraction product
  assign prod = gain_o * attack_i;
  assign cut  = prod[31:16];

  always @* begin
    gain_nxt = gain_o;
    // cut only while above the high threshold; bigger code, bigger cut
    if (step_i && (avg_amp_i > thr_hi_i)) begin
      gain_nxt = gain_o - cut;
    end
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gain_o <= `GAIN_UNITY;
    end else begin
      gain_o <= gain_nxt;
    end
  end

endmodule // agc_gain_stage

// file: design/agc_attack_rate_control.v
// Purpose: attack-rate registers and the gain stages they steer
// Assumes: register port and sample strobes synchronous to clk_i
// Notes:   gain state readable through a select register
//
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ns
`include "agc_attack_regs.vh"

module agc_attack_rate_control (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rdata_o,
  // satellite path
  input  wire        sat_step_i,
  input  wire [31:0] sat_avg_amp_i,
  input  wire [15:0] sat_thr_hi_i,
  // mono path
  input  wire        mono_step_i,
  input  wire [15:0] mono_avg_amp_i,
  input  wire [15:0] mono_thr_hi_i,
  // gains
  output reg  [31:0] sat_gain_o,
  output reg  [15:0] mono_gain_o
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg  [7:0]  sat_attack_low_r;
  reg  [7:0]  sat_attack_high_r;
  reg  [7:0]  mono_attack_low_r;
  reg  [7:0]  mono_attack_high_r;
  reg  [1:0]  status_sel_r;
  reg  [7:0]  rdata_nxt;
  wire [15:0] sat_attack;
  wire [15:0] mono_attack;
  wire [31:0] sat_gain;
  wire [15:0] mono_gain;
  reg  [15:0] sel_gain;

  assign sat_attack  = {sat_attack_high_r, sat_attack_low_r};
  assign mono_attack = {mono_attack_high_r, mono_attack_low_r};

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sat_attack_low_r   <= `ATTACK_RESET;
      sat_attack_high_r  <= `ATTACK_RESET;
      mono_attack_low_r  <= `ATTACK_RESET;
      mono_attack_high_r <= `ATTACK_RESET;
      status_sel_r       <= 2'h0;
    end else if (wr_i) begin
      case (addr_i)
        `SAT_ATTACK_LOW_ADDR:   sat_attack_low_r   <= wdata_i;
        `SAT_ATTACK_HIGH_ADDR:  sat_attack_high_r  <= wdata_i;
        `MONO_ATTACK_LOW_ADDR:  mono_attack_low_r  <= wdata_i;
        `MONO_ATTACK_HIGH_ADDR: mono_attack_high_r <= wdata_i;
        `GAIN_STATUS_SEL_ADDR:  status_sel_r       <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read path
  // ------------------------------------------------------------------
  // sel 0/1 satellite channels, 2 mono, 3 reads zero
  always @* begin
    case (status_sel_r)
      2'h0:    sel_gain = sat_gain[15:0];
      2'h1:    sel_gain = sat_gain[31:16];
      2'h2:    sel_gain = mono_gain;
      default: sel_gain = 16'h0000;
    endcase
  end

  always @* begin
    case (addr_i)
      `SAT_ATTACK_LOW_ADDR:   rdata_nxt = sat_attack_low_r;
      `SAT_ATTACK_HIGH_ADDR:  rdata_nxt = sat_attack_high_r;
      `MONO_ATTACK_LOW_ADDR:  rdata_nxt = mono_attack_low_r;
      `MONO_ATTACK_HIGH_ADDR: rdata_nxt = mono_attack_high_r;
      `GAIN_STATUS_SEL_ADDR:  rdata_nxt = {6'h00, status_sel_r};
      `GAIN_STATUS_LOW_ADDR:  rdata_nxt = sel_gain[7:0];
      `GAIN_STATUS_HIGH_ADDR: rdata_nxt = sel_gain[15:8];
      default:                rdata_nxt = `UNMAPPED_READ;
    endcase
  end

  // read data held only in the cycle after the strobe
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rdata_nxt;
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ------------------------------------------------------------------
  // gain stages
  // ------------------------------------------------------------------
  // both halves of the 16-bit code change in separate writes, so a
  // stage may briefly see a mixed code; write low then high in quiet time
  genvar ch;
  generate
    for (ch = 0; ch < `SAT_CHANNELS; ch = ch + 1) begin : g_sat
      agc_gain_stage u_sat (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .attack_i  (sat_attack),
        .step_i    (sat_step_i),
        .avg_amp_i (sat_avg_amp_i[ch*16 +: 16]),
        .thr_hi_i  (sat_thr_hi_i),
        .gain_o    (sat_gain[ch*16 +: 16])
      );
    end
  endgenerate

  agc_gain_stage u_mono (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .attack_i  (mono_attack),
    .step_i    (mono_step_i),
    .avg_amp_i (mono_avg_amp_i),
    .thr_hi_i  (mono_thr_hi_i),
    .gain_o    (mono_gain)
  );

  // registered copies so outputs come from flip-flops
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sat_gain_o  <= {`GAIN_UNITY, `GAIN_UNITY};
      mono_gain_o <= `GAIN_UNITY;
    end else begin
      sat_gain_o  <= sat_gain;
      mono_gain_o <= mono_gain;
    end
  end

endmodule // agc_attack_rate_control

// file: testbench/agc_attack_rate_control_checker.sv
// Purpose: port assertions for the attack-rate block
// Assumes: one clock, async reset
// Notes:   codes are tracked from writes
`timescale 1ns/1ns
module agc_attack_rate_control_checker (
  input wire        clk_i, rst_i, wr_i, rd_i, sat_step_i, mono_step_i,
  input wire [7:0]  addr_i, wdata_i, rdata_o,
  input wire [31:0] sat_avg_amp_i, sat_gain_o,
  input wire [15:0] sat_thr_hi_i, mono_avg_amp_i, mono_thr_hi_i,
  input wire [15:0] mono_gain_o
);
  logic [15:0] sc_r, mc_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sc_r <= 16'h0000;
      mc_r <= 16'h0000;
    end else if (wr_i) begin
      if (addr_i == 8'h1A) sc_r[7:0] <= wdata_i;
      if (addr_i == 8'h1B) sc_r[15:8] <= wdata_i;
      if (addr_i == 8'h1F) mc_r[7:0] <= wdata_i;
      if (addr_i == 8'h20) mc_r[15:8] <= wdata_i;
    end
  end
  function automatic logic [15:0] cut(logic [15:0] g, c);
    return g - 16'((32'(g) * 32'(c)) >> 16);
  endfunction
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // --------
  // rules
  // --------
  sequence s_m; mono_step_i && mono_avg_amp_i > mono_thr_hi_i; endsequence
  sequence s_0; sat_step_i && sat_avg_amp_i[15:0] > sat_thr_hi_i; endsequence
  sequence s_1; sat_step_i && sat_avg_amp_i[31:16] > sat_thr_hi_i; endsequence
  property p_idle; !rd_i |=> rdata_o == 8'h00; endproperty
  a_idle: assert property (p_idle)
    else $error("idle");
  property p_srb; rd_i && addr_i == 8'h1B && !$past(wr_i) &&
    $past(wr_i && addr_i == 8'h1B, 2) |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_srb: assert property (p_srb)
    else $error("srb");
  property p_mrb; rd_i && addr_i == 8'h1F && !$past(wr_i) &&
    $past(wr_i && addr_i == 8'h1F, 2) |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_mrb: assert property (p_mrb)
    else $error("mrb");
  property p_mcut;
    s_m |=> ##1 mono_gain_o == cut($past(mono_gain_o), $past(mc_r, 2));
  endproperty
  a_mcut: assert property (p_mcut)
    else $error("mcut");
  property p_cut0; s_0 |=> ##1 sat_gain_o[15:0] ==
    cut($past(sat_gain_o[15:0]), $past(sc_r, 2)); endproperty
  a_cut0: assert property (p_cut0)
    else $error("cut0");
  property p_cut1; s_1 |=> ##1 sat_gain_o[31:16] ==
    cut($past(sat_gain_o[31:16]), $past(sc_r, 2)); endproperty
  a_cut1: assert property (p_cut1)
    else $error("cut1");
  property p_mhold; !(mono_step_i && mono_avg_amp_i > mono_thr_hi_i)
    |=> ##1 $stable(mono_gain_o); endproperty
  a_mhold: assert property (p_mhold)
    else $error("mhold");
  property p_shold; !sat_step_i |=> ##1 $stable(sat_gain_o); endproperty
  a_shold: assert property (p_shold)
    else $error("shold");
endmodule // agc_attack_rate_control_checker
bind agc_attack_rate_control agc_attack_rate_control_checker chk (.*);

// file: testbench/agc_attack_rate_control_tb.sv
// Purpose: random and corner tests of the attack-rate block
// Assumes: codes and gains modelled in the bench
// Notes:   gains compared two cycles after each step
`timescale 1ns/1ns
module agc_attack_rate_control_tb;
  logic        clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic        sat_step_i = 0, mono_step_i = 0;
  logic [7:0]  addr_i = 0, wdata_i = 0, rdata_o;
  logic [31:0] sat_avg_amp_i = 0, sat_gain_o;
  logic [15:0] sat_thr_hi_i = 0, mono_avg_amp_i = 0, mono_thr_hi_i = 0;
  logic [15:0] mono_gain_o, sc = 0, mc = 0;
  logic [15:0] g0 = 16'hFFFF, g1 = 16'hFFFF, gm = 16'hFFFF;
  logic [7:0]  ad [4] = '{8'h1A, 8'h1B, 8'h1F, 8'h20};
  int          n_errors = 0, cmp_count = 0, cyc = 0;
  agc_attack_rate_control dut (.*);
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  function automatic logic [15:0] cut(logic [15:0] g, c, logic h);
    return h ? g - 16'((32'(g) * 32'(c)) >> 16) : g;
  endfunction
  // gain expected through the status select register
  function automatic logic [15:0] selg(int s);
    return s == 0 ? g0 : s == 1 ? g1 : s == 2 ? gm : 16'h0000;
  endfunction
  task automatic check(logic [15:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a == 8'h1A) sc[7:0] = d;
    if (a == 8'h1B) sc[15:8] = d;
    if (a == 8'h1F) mc[7:0] = d;
    if (a == 8'h20) mc[15:8] = d;
  endtask
  task automatic rd(logic [7:0] a, e);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, e);
  endtask
  task automatic step(logic s, m);
    @(posedge clk_i);
    {sat_step_i, mono_step_i, sat_avg_amp_i} <= {s, m, $urandom};
    {sat_thr_hi_i, mono_avg_amp_i, mono_thr_hi_i} <= 48'({$urandom, $urandom});
    @(posedge clk_i);
    {sat_step_i, mono_step_i} <= 2'b00;
    g0 = cut(g0, sc, s && sat_avg_amp_i[15:0] > sat_thr_hi_i);
    g1 = cut(g1, sc, s && sat_avg_amp_i[31:16] > sat_thr_hi_i);
    gm = cut(gm, mc, m && mono_avg_amp_i > mono_thr_hi_i);
    @(posedge clk_i);
    #1 check(sat_gain_o[15:0], g0);
    check(sat_gain_o[31:16], g1);
    check(mono_gain_o, gm);
  endtask
  initial begin
    void'($urandom(47528));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ad[i]) rd(ad[i], 8'h00);
    for (int k = 0; k < 60; k++) begin
      if (k % 10 == 0) begin
        // mid-run reset brings codes to zero and gains back to unity
        if (k == 30) begin
          @(posedge clk_i);
          rst_i <= 1'b1;
          @(posedge clk_i);
          rst_i <= 1'b0;
          {sc, mc, g0, g1, gm} = {32'h0000_0000, 48'hFFFF_FFFF_FFFF};
          foreach (ad[i]) rd(ad[i], 8'h00);
        end
        // corner codes: all ones, then all zero
        foreach (ad[i]) begin
          wr(ad[i], k == 20 ? 8'hFF : k == 40 ? 8'h00 : 8'($urandom));
          rd(ad[i], i < 2 ? sc[i*8 +: 8] : mc[i*8-16 +: 8]);
        end
        wr(8'h1C, 8'h5A);
        rd(8'h1C, 8'h00);
        // every stage gain is visible through the status select
        for (int s = 0; s < 4; s++) begin
          wr(8'hF0, 8'(s));
          rd(8'hF0, 8'(s));
          rd(8'hF1, 8'(selg(s)));
          rd(8'hF2, 8'(selg(s) >> 8));
        end
      end
      step($urandom % 4 != 0, $urandom % 3 != 0);
    end
    complete_run();
  end
endmodule // agc_attack_rate_control_tb
